// >>> design/cfg_store_pkg.sv
// shared constants, types and tables for the configuration store link
// How it works
// - busy flag high while a store runs
// - host writes to busy flag are dropped
// - host sends no writes during a store
// - reads keep being answered during a store
// - rate change: bypass PLL2, write, re-enable
// - amount change: bypass PLL2, write, re-enable
// - amount field decodes center and down spread
// - zero amount powers spread circuitry down
// - stored lock bit blocks all later stores
// - locked device still applies volatile writes
// - block read length from byte count
// - store starts only on trigger rising edge
// - trigger stays high; host writes zero, one
// - host writes trigger last
// - host never interrupts a running store
package cfg_store_pkg;
    // ==========================================
    // device byte addresses on the link
    localparam logic [7:0] ADDR_PLL_BYPASS = 8'h03;
    localparam logic [7:0] ADDR_OUT_FIVE = 8'h18;
    localparam logic [7:0] ADDR_SPREAD = 8'h19;
    localparam logic [7:0] ADDR_READ_LEN = 8'h1a;
    // ==========================================
    // field positions
    localparam int BUSY_BIT = 7;
    localparam int LOCK_BIT = 7;
    localparam int TRIG_BIT = 7;
    localparam int BYPASS2_BIT = 6;
    localparam int AMT_MSB = 6;
    localparam int AMT_LSB = 4;
    localparam int DOWN_BIT = 6;
    localparam int RATE_MSB = 3;
    localparam int LEN_MSB = 6;
    // ==========================================
    // reset values
    localparam logic [7:0] OUT_FIVE_RESET = 8'h3a;
    localparam logic [7:0] SPREAD_RESET = 8'h09;
    localparam logic [7:0] READ_LEN_RESET = 8'h1b;
    localparam logic [2:0] AMT_NONE = 3'h0;
    localparam logic [6:0] LEN_ZERO = 7'h00;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int STORE_TIME_NS = 20000;
    localparam int STORE_CYCLES_DEFAULT = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================
    // host register map (avalon byte addresses)
    localparam logic [4:0] AV_CMD = 5'h00;
    localparam logic [4:0] AV_ADDR = 5'h04;
    localparam logic [4:0] AV_WDATA = 5'h08;
    localparam logic [4:0] AV_AUX = 5'h0c;
    localparam logic [4:0] AV_STATUS = 5'h10;
    localparam logic [4:0] AV_IRQ = 5'h14;
    localparam logic [4:0] AV_MASK = 5'h18;
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_STORE = 1;
    localparam int IRQ_REFUSED = 2;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WRITE = 3'h1,
        OP_READ = 3'h2,
        OP_STORE = 3'h3,
        OP_SPREAD = 3'h4
    } op_t;

    // modulation factor per rate code
    function automatic logic [12:0] rate_factor(input logic [3:0] code);
        case (code)
            4'h0: rate_factor = 13'h1630;
            4'h1: rate_factor = 13'h1524;
            4'h2: rate_factor = 13'h1418;
            4'h3: rate_factor = 13'h130c;
            4'h4: rate_factor = 13'h1200;
            4'h5: rate_factor = 13'h10f4;
            4'h6: rate_factor = 13'h0fe8;
            4'h7: rate_factor = 13'h0edc;
            4'h8: rate_factor = 13'h0dd0;
            4'h9: rate_factor = 13'h0cd6;
            4'ha: rate_factor = 13'h0bb8;
            4'hb: rate_factor = 13'h0aac;
            4'hc: rate_factor = 13'h09a0;
            4'hd: rate_factor = 13'h0894;
            4'he: rate_factor = 13'h0788;
            default: rate_factor = 13'h067c;
        endcase
    endfunction
endpackage

// >>> design/cfg_link_if.sv
// byte access link between the configuration host and the device
interface cfg_link_if;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;

    modport host (
        output req,
        output wr,
        output addr,
        output wdata,
        input ack,
        input rdata
    );

    modport device (
        input req,
        input wr,
        input addr,
        input wdata,
        output ack,
        output rdata
    );
endinterface

// >>> design/cfg_store_device.sv
// device end: configuration bytes 24..26, nonvolatile store engine, spread decode
//
// Local design decision: the Avalon-MM slave port.
module cfg_store_device
    import cfg_store_pkg::*;
#(
    parameter int STORE_CYCLES = STORE_CYCLES_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst_n,
    cfg_link_if.device link,
    output logic storeBusy,
    output logic nvLocked,
    output logic storeRefused,
    output logic spreadPowerDown,
    output logic spreadDown,
    output logic [2:0] spreadAmountSel,
    output logic [12:0] spreadRateFactor,
    output logic [6:0] blockReadLength,
    output logic [6:0] outFiveSetup,
    output logic [7:0] nvByte24,
    output logic [7:0] nvByte25,
    output logic [7:0] nvByte26
);
    localparam int CNT_W = $clog2(STORE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STORE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_STORE = 2'b10
    } store_state_t;

    // ==========================================
    // register file and link answer
    logic ack_reg;
    logic ack_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] outFive_reg;
    logic [7:0] outFive_next;
    logic [7:0] spread_reg;
    logic [7:0] spread_next;
    logic [7:0] readLen_reg;
    logic [7:0] readLen_next;
    logic refused_reg;
    logic refused_next;
    logic pd_reg;
    logic pd_next;
    logic down_reg;
    logic down_next;
    logic [2:0] amt_reg;
    logic [2:0] amt_next;
    logic [12:0] rate_reg;
    logic [12:0] rate_next;
    logic storeStart;

    // ==========================================
    // store engine state
    store_state_t state_reg;
    store_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic busy_reg;
    logic busy_next;
    logic lock_reg;
    logic lock_next;
    logic [7:0] snap24_reg;
    logic [7:0] snap24_next;
    logic [7:0] snap25_reg;
    logic [7:0] snap25_next;
    logic [7:0] snap26_reg;
    logic [7:0] snap26_next;
    logic [7:0] nv24_reg;
    logic [7:0] nv24_next;
    logic [7:0] nv25_reg;
    logic [7:0] nv25_next;
    logic [7:0] nv26_reg;
    logic [7:0] nv26_next;

    // ==========================================
    // register file next state
    always_comb begin
        ack_next = 1'b0;
        rdata_next = rdata_reg;
        outFive_next = outFive_reg;
        spread_next = spread_reg;
        readLen_next = readLen_reg;
        refused_next = 1'b0;
        storeStart = 1'b0;
        if (link.req && !ack_reg) begin
            ack_next = 1'b1;
            if (!link.wr) begin
                // reads are served whether or not a store runs
                case (link.addr)
                    ADDR_OUT_FIVE: rdata_next = {busy_reg, outFive_reg[BUSY_BIT-1:0]};
                    ADDR_SPREAD: rdata_next = spread_reg;
                    ADDR_READ_LEN: rdata_next = readLen_reg;
                    default: rdata_next = 8'h00;
                endcase
            end else if (state_reg == ST_STORE) begin
                // a write landing mid-store is dropped so the captured image stays whole
                refused_next = 1'b1;
            end else begin
                // volatile writes apply at once, locked or not
                case (link.addr)
                    ADDR_OUT_FIVE: outFive_next = {1'b0, link.wdata[BUSY_BIT-1:0]};
                    ADDR_SPREAD: spread_next = link.wdata;
                    ADDR_READ_LEN: begin
                        readLen_next[TRIG_BIT] = link.wdata[TRIG_BIT];
                        if (link.wdata[LEN_MSB:0] != LEN_ZERO) begin
                            readLen_next[LEN_MSB:0] = link.wdata[LEN_MSB:0];
                        end
                        if (!readLen_reg[TRIG_BIT] && link.wdata[TRIG_BIT]) begin
                            if (lock_reg) begin
                                refused_next = 1'b1;
                            end else begin
                                storeStart = 1'b1;
                            end
                        end
                    end
                    default: refused_next = 1'b0;
                endcase
            end
        end
        amt_next = spread_next[AMT_MSB:AMT_LSB];
        down_next = spread_next[DOWN_BIT];
        pd_next = (spread_next[AMT_MSB:AMT_LSB] == AMT_NONE);
        rate_next = rate_factor(spread_next[RATE_MSB:0]);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            outFive_reg <= OUT_FIVE_RESET;
            spread_reg <= SPREAD_RESET;
            readLen_reg <= READ_LEN_RESET;
            refused_reg <= 1'b0;
            pd_reg <= 1'b1;
            down_reg <= 1'b0;
            amt_reg <= AMT_NONE;
            rate_reg <= rate_factor(SPREAD_RESET[RATE_MSB:0]);
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            outFive_reg <= outFive_next;
            spread_reg <= spread_next;
            readLen_reg <= readLen_next;
            refused_reg <= refused_next;
            pd_reg <= pd_next;
            down_reg <= down_next;
            amt_reg <= amt_next;
            rate_reg <= rate_next;
        end
    end

    // ==========================================
    // store engine next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        lock_next = lock_reg;
        snap24_next = snap24_reg;
        snap25_next = snap25_reg;
        snap26_next = snap26_reg;
        nv24_next = nv24_reg;
        nv25_next = nv25_reg;
        nv26_next = nv26_reg;
        case (state_reg)
            ST_IDLE: begin
                if (storeStart) begin
                    state_next = ST_STORE;
                    cnt_next = CNT_LOAD;
                    busy_next = 1'b1;
                    snap24_next = outFive_next;
                    snap25_next = spread_next;
                    snap26_next = readLen_next;
                end
            end
            ST_STORE: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ST_IDLE;
                    busy_next = 1'b0;
                    nv24_next = snap24_reg;
                    nv25_next = snap25_reg;
                    nv26_next = snap26_reg;
                    // only the stored copy of the lock bit counts, and only reset clears it
                    lock_next = lock_reg | snap25_reg[LOCK_BIT];
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
            busy_reg <= 1'b0;
            lock_reg <= 1'b0;
            snap24_reg <= OUT_FIVE_RESET;
            snap25_reg <= SPREAD_RESET;
            snap26_reg <= READ_LEN_RESET;
            nv24_reg <= OUT_FIVE_RESET;
            nv25_reg <= SPREAD_RESET;
            nv26_reg <= READ_LEN_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            lock_reg <= lock_next;
            snap24_reg <= snap24_next;
            snap25_reg <= snap25_next;
            snap26_reg <= snap26_next;
            nv24_reg <= nv24_next;
            nv25_reg <= nv25_next;
            nv26_reg <= nv26_next;
        end
    end

    // ==========================================
    // outputs
    assign link.ack = ack_reg;
    assign link.rdata = rdata_reg;
    assign storeBusy = busy_reg;
    assign nvLocked = lock_reg;
    assign storeRefused = refused_reg;
    assign spreadPowerDown = pd_reg;
    assign spreadDown = down_reg;
    assign spreadAmountSel = amt_reg;
    assign spreadRateFactor = rate_reg;
    assign blockReadLength = readLen_reg[LEN_MSB:0];
    assign outFiveSetup = outFive_reg[BUSY_BIT-1:0];
    assign nvByte24 = nv24_reg;
    assign nvByte25 = nv25_reg;
    assign nvByte26 = nv26_reg;
endmodule

// >>> design/cfg_store_host.sv
// host end: avalon command registers driving byte sequences over the link
module cfg_store_host
    import cfg_store_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    cfg_link_if.host link
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_LOAD = 3'b010,
        H_WAIT = 3'b100
    } host_state_t;

    host_state_t state_reg, state_next;
    op_t op_reg, op_next;
    logic [1:0] step_reg, step_next;
    logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next, aux_reg, aux_next, rbyte_reg, rbyte_next;
    logic [IRQ_W-1:0] irqStat_reg, irqStat_next, irqMask_reg, irqMask_next;
    logic irq_reg, irq_next, wait_reg, wait_next;
    logic [31:0] avRdata_reg, avRdata_next;
    logic req_reg, req_next, wr_reg, wr_next;
    logic [7:0] lAddr_reg, lAddr_next, lData_reg, lData_next;
    logic stepWr, stepLast, stepPoll, accept;
    logic [7:0] stepAddr, stepData;
    logic [IRQ_W-1:0] events;

    // ==========================================
    // sequence table per command
    always_comb begin
        stepWr = 1'b1;
        stepAddr = addr_reg;
        stepData = wdata_reg;
        stepLast = 1'b1;
        stepPoll = 1'b0;
        case (op_reg)
            OP_READ: stepWr = 1'b0;
            OP_STORE: begin
                // trigger goes zero then one, after all other writes
                stepAddr = ADDR_READ_LEN;
                stepData = {step_reg[0], wdata_reg[LEN_MSB:0]};
                stepLast = 1'b0;
                if (step_reg == 2'h2) begin
                    // only reads until busy falls, never cut short
                    stepWr = 1'b0;
                    stepAddr = ADDR_OUT_FIVE;
                    stepPoll = 1'b1;
                end
            end
            OP_SPREAD: begin
                // bypass PLL2, write byte 25, re-enable
                stepAddr = (step_reg == 2'h1) ? ADDR_SPREAD : ADDR_PLL_BYPASS;
                stepData = (step_reg == 2'h1) ? wdata_reg : aux_reg;
                stepData[BYPASS2_BIT] = (step_reg == 2'h1) ? wdata_reg[BYPASS2_BIT] : (step_reg == 2'h0);
                stepLast = (step_reg == 2'h2);
            end
            default: stepWr = 1'b1;
        endcase
    end

    // ==========================================
    // avalon slave, sequencer and interrupt
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        aux_next = aux_reg;
        rbyte_next = rbyte_reg;
        irqMask_next = irqMask_reg;
        avRdata_next = avRdata_reg;
        req_next = req_reg;
        wr_next = wr_reg;
        lAddr_next = lAddr_reg;
        lData_next = lData_reg;
        events = '0;
        accept = (avs_read || avs_write) && !wait_reg;
        wait_next = !((avs_read || avs_write) && wait_reg);
        if ((avs_read || avs_write) && wait_reg) begin
            case (avs_address)
                AV_ADDR: avRdata_next = {24'h000000, addr_reg};
                AV_WDATA: avRdata_next = {24'h000000, wdata_reg};
                AV_AUX: avRdata_next = {24'h000000, aux_reg};
                AV_STATUS: avRdata_next = {16'h0000, rbyte_reg, 7'h00, (state_reg != H_IDLE)};
                AV_IRQ: avRdata_next = {29'h00000000, irqStat_reg};
                AV_MASK: avRdata_next = {29'h00000000, irqMask_reg};
                default: avRdata_next = 32'h00000000;
            endcase
        end
        if (accept && avs_write) begin
            case (avs_address)
                AV_ADDR: addr_next = avs_writedata[7:0];
                AV_WDATA: wdata_next = avs_writedata[7:0];
                AV_AUX: aux_next = avs_writedata[7:0];
                AV_MASK: irqMask_next = avs_writedata[IRQ_W-1:0];
                default: addr_next = addr_reg;
            endcase
        end
        case (state_reg)
            H_IDLE: begin
                if (accept && avs_write && avs_address == AV_CMD) begin
                    if (avs_writedata[2:0] == OP_NONE || avs_writedata[2:0] > OP_SPREAD) begin
                        events[IRQ_REFUSED] = 1'b1;
                    end else begin
                        op_next = op_t'(avs_writedata[2:0]);
                        step_next = 2'h0;
                        state_next = H_LOAD;
                    end
                end
            end
            H_LOAD: begin
                req_next = 1'b1;
                wr_next = stepWr;
                lAddr_next = stepAddr;
                lData_next = stepData;
                state_next = H_WAIT;
            end
            H_WAIT: begin
                if (link.ack) begin
                    req_next = 1'b0;
                    if (!wr_reg) begin
                        rbyte_next = link.rdata;
                    end
                    if (stepLast || (stepPoll && !link.rdata[BUSY_BIT])) begin
                        state_next = H_IDLE;
                        events[IRQ_DONE] = 1'b1;
                        events[IRQ_STORE] = (op_reg == OP_STORE);
                    end else begin
                        state_next = H_LOAD;
                        step_next = stepPoll ? step_reg : step_reg + 2'h1;
                    end
                end
            end
            default: state_next = H_IDLE;
        endcase
        if (accept && avs_write && avs_address == AV_CMD && state_reg != H_IDLE) begin
            events[IRQ_REFUSED] = 1'b1;
        end
        // set wins over the read-clear
        irqStat_next = ((accept && avs_read && avs_address == AV_IRQ) ? irqStat_reg & ~avRdata_reg[IRQ_W-1:0]
            : irqStat_reg) | events;
        irq_next = |(irqStat_next & irqMask_next);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= H_IDLE;
            op_reg <= OP_NONE;
            step_reg <= 2'h0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            aux_reg <= 8'h00;
            rbyte_reg <= 8'h00;
            irqStat_reg <= '0;
            irqMask_reg <= '0;
            irq_reg <= 1'b0;
            wait_reg <= 1'b1;
            avRdata_reg <= 32'h00000000;
            req_reg <= 1'b0;
            wr_reg <= 1'b0;
            lAddr_reg <= 8'h00;
            lData_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            aux_reg <= aux_next;
            rbyte_reg <= rbyte_next;
            irqStat_reg <= irqStat_next;
            irqMask_reg <= irqMask_next;
            irq_reg <= irq_next;
            wait_reg <= wait_next;
            avRdata_reg <= avRdata_next;
            req_reg <= req_next;
            wr_reg <= wr_next;
            lAddr_reg <= lAddr_next;
            lData_reg <= lData_next;
        end
    end

    assign avs_readdata = avRdata_reg;
    assign avs_waitrequest = wait_reg;
    assign irq = irq_reg;
    assign link.req = req_reg;
    assign link.wr = wr_reg;
    assign link.addr = lAddr_reg;
    assign link.wdata = lData_reg;
endmodule

// >>> dv/cfg_store_monitor.sv
// checker on the link between host end and device end
module cfg_store_monitor
    import cfg_store_pkg::*;
#(
    parameter int STORE_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic storeBusy,
    input wire logic nvLocked,
    input wire logic spreadPowerDown,
    input wire logic [2:0] spreadAmountSel
);
    // ==========================================
    // helper state
    logic [15:0] busyCnt_reg;
    logic [15:0] busyCnt_next;
    logic trig_reg;
    logic trig_next;
    logic taken;
    always_comb begin
        taken = req && !ack;
        busyCnt_next = storeBusy ? busyCnt_reg + 16'h1 : 16'h0;
        trig_next = (taken && wr && addr == ADDR_READ_LEN && !storeBusy) ? wdata[TRIG_BIT] : trig_reg;
    end
    always_ff @(posedge core_clk) begin
        busyCnt_reg <= rst_n ? busyCnt_next : 16'h0;
        trig_reg <= rst_n ? trig_next : 1'b0;
    end
    // ==========================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence trigWrite;
        taken && wr && addr == ADDR_READ_LEN && wdata[TRIG_BIT];
    endsequence
    sequence freshEdge;
        trigWrite ##0 (!trig_reg && !storeBusy);
    endsequence
    a_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    a_ack_answer: assert property (taken |=> ack) else $error("request not answered");
    a_read_busy: assert property (taken && !wr && storeBusy |=> ack) else $error("read not answered in store");
    a_store_start: assert property (freshEdge ##0 !nvLocked |-> ##[1:2] storeBusy)
        else $error("store not started");
    a_held_trigger: assert property (trigWrite ##0 (trig_reg && !storeBusy) |=> !storeBusy [*3])
        else $error("held trigger started a store");
    a_lock_refuse: assert property (freshEdge ##0 nvLocked |=> !storeBusy [*3])
        else $error("store while locked");
    a_busy_length: assert property ($fell(storeBusy) |-> busyCnt_reg == STORE_CYCLES)
        else $error("busy length wrong");
    a_busy_flag: assert property (taken && !wr && addr == ADDR_OUT_FIVE && storeBusy
        |=> rdata[BUSY_BIT]) else $error("busy flag not read high");
    a_busy_ignore: assert property (taken && wr && addr == ADDR_OUT_FIVE && wdata[BUSY_BIT] && !storeBusy
        |=> !storeBusy [*2]) else $error("busy flag writable");
    a_spread_off: assert property (spreadPowerDown == (spreadAmountSel == AMT_NONE))
        else $error("spread power down wrong");
endmodule

// >>> dv/tb_config_store_and_spread_control.sv
// self-checking bench: host end and device end joined by the link
module tb_config_store_and_spread_control
    import cfg_store_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h seen %h", nm, e, s); end end
    localparam int STC = 4;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, storeBusy, nvLocked, storeRefused, spreadPowerDown, spreadDown;
    logic [2:0] spreadAmountSel;
    logic [12:0] spreadRateFactor;
    logic [6:0] blockReadLength, outFiveSetup, len;
    logic [7:0] nvByte24, nvByte25, nvByte26;
    logic [63:0] expQ[$];
    logic [63:0] ex;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [12:0] factors [16] = '{13'h1630, 13'h1524, 13'h1418, 13'h130c, 13'h1200, 13'h10f4, 13'h0fe8,
        13'h0edc, 13'h0dd0, 13'h0cd6, 13'h0bb8, 13'h0aac, 13'h09a0, 13'h0894, 13'h0788, 13'h067c};
    always #2.5 core_clk = ~core_clk;
    cfg_link_if link();
    cfg_store_device #(.STORE_CYCLES(STC)) cfg_store_device_i (.core_clk, .rst_n, .link, .storeBusy, .nvLocked,
        .storeRefused, .spreadPowerDown, .spreadDown, .spreadAmountSel, .spreadRateFactor, .blockReadLength,
        .outFiveSetup, .nvByte24, .nvByte25, .nvByte26);
    cfg_store_host cfg_store_host_i (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .irq, .link);
    cfg_store_monitor #(.STORE_CYCLES(STC)) cfg_store_monitor_i (.core_clk, .rst_n, .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .storeBusy,
        .nvLocked, .spreadPowerDown, .spreadAmountSel);
    // ==========================================
    // avalon master and result watcher
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [63:0] e);
        int t;
        @(posedge core_clk);
        if (!w) expQ.push_back(e);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        if (t == 50) n_mismatch++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
            ex = expQ.pop_front();
            if (ex[63:32] != 32'h0) `CHK("readdata", ex[31:0], avs_readdata & ex[63:32])
        end
    end
    // host command, then poll until idle
    task automatic op(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
        av(1'b1, AV_ADDR, {24'h0, a}, 64'h0);
        av(1'b1, AV_WDATA, {24'h0, d}, 64'h0);
        av(1'b1, AV_AUX, {24'h0, x}, 64'h0);
        av(1'b1, AV_CMD, {29'h0, c}, 64'h0);
        rd = 32'h1;
        for (int i = 0; i < 300 && rd[0]; i++) av(1'b0, AV_STATUS, 32'h0, 64'h0);
        if (rd[0]) n_mismatch++;
    endtask
    task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
        op(3'h2, a, 8'h00, 8'h00);
        av(1'b0, AV_STATUS, 32'h0, {32'h0000ff00, 16'h0, e, 8'h00});
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    // ==========================================
    // tests
    initial begin
        void'($urandom(32'h9f78));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        av(1'b1, AV_MASK, 32'h1, 64'h0);
        chk_byte(ADDR_OUT_FIVE, 8'h3a);
        chk_byte(ADDR_SPREAD, 8'h09);
        chk_byte(ADDR_READ_LEN, 8'h1b);
        `CHK("rate", 13'h0cd6, spreadRateFactor)
        `CHK("irq", 1'b1, irq)
        av(1'b0, AV_IRQ, 32'h0, {32'h1, 32'h1});
        av(1'b1, AV_MASK, 32'h0, 64'h0);
        `CHK("irq", 1'b0, irq)
        $display("test reset and interrupt done");
        for (int i = 0; i < 16; i++) begin
            op(3'h4, 8'h00, {1'b0, i[2:0], i[3:0]}, 8'($urandom));
            `CHK("rate", factors[i], spreadRateFactor)
            `CHK("amount", i[2:0], spreadAmountSel)
            `CHK("down", i[2], spreadDown)
            `CHK("powerdown", i[2:0] == 3'h0, spreadPowerDown)
        end
        `CHK("irq masked", 1'b0, irq)
        $display("test spread done");
        len = 7'($urandom_range(127, 1));
        op(3'h1, ADDR_READ_LEN, {1'b0, len}, 8'h00);
        `CHK("length", len, blockReadLength)
        op(3'h1, ADDR_READ_LEN, 8'h00, 8'h00);
        `CHK("length", len, blockReadLength)
        op(3'h1, ADDR_OUT_FIVE, 8'hff, 8'h00);
        chk_byte(ADDR_OUT_FIVE, 8'h7f);
        `CHK("setup", 7'h7f, outFiveSetup)
        $display("test length and flag done");
        op(3'h3, 8'h00, 8'h1b, 8'h00);
        `CHK("stored", {8'h7f, 8'h7f, 8'h9b}, {nvByte24, nvByte25, nvByte26})
        chk_byte(ADDR_READ_LEN, 8'h9b);
        op(3'h1, ADDR_READ_LEN, 8'h9b, 8'h00);
        `CHK("busy", 1'b0, storeBusy)
        op(3'h1, ADDR_SPREAD, 8'h80, 8'h00);
        `CHK("lock", 1'b0, nvLocked)
        op(3'h3, 8'h00, 8'h1b, 8'h00);
        `CHK("lock", 1'b1, nvLocked)
        op(3'h1, ADDR_SPREAD, 8'h15, 8'h00);
        `CHK("amount", 3'h1, spreadAmountSel)
        op(3'h3, 8'h00, 8'h1b, 8'h00);
        `CHK("stored", 8'h80, nvByte25)
        $display("test store and lock done");
        av(1'b1, AV_CMD, 32'h7, 64'h0);
        av(1'b0, AV_IRQ, 32'h0, {32'h4, 32'h4});
        av(1'b0, 5'h1c, 32'h0, {32'hffffffff, 32'h0});
        $display("test refusal done");
        final_report();
    end
endmodule
